// >>> design/lvd_sysctl_map.svh
// Register offsets, field positions, reset values and codes of the system-control bank.
// Assumes a byte-addressed Avalon-MM slave with one aligned 32-bit word per register.
`ifndef LVD_SYSCTL_MAP_SVH
`define LVD_SYSCTL_MAP_SVH

// Byte offsets
`define OFS_FLASH_PROTECT_UNLOCK 5'h00
`define OFS_BOOT_SIGNATURE 5'h04
`define OFS_LOW_VOLTAGE_CONTROL_STATUS 5'h08
`define OFS_EVENT_STATUS 5'h0C
`define OFS_EVENT_MASK 5'h10

// Unlock sequence codes
`define UNLOCK_FIRST_CODE 8'h55
`define UNLOCK_SECOND_CODE 8'hAA

// Field positions in the low-voltage control and status register
`define LV_FLAG_BIT 7
`define LV_ACK_BIT 6
`define LV_IRQ_EN_BIT 5
`define LV_RESET_EN_BIT 4
`define LV_STOP_EN_BIT 3
`define LV_DETECT_EN_BIT 2
`define LV_BANDGAP_EN_BIT 0

// Field position of the unlock flag
`define UNLOCK_FLAG_BIT 0

// Event status bits
`define EV_LOW_VOLTAGE_BIT 0
`define EV_UNLOCK_SET_BIT 1
`define EV_UNLOCK_CLEAR_BIT 2
`define EV_WIDTH 3

// Reset values
`define LV_CTRL_RESET 8'h1C
`define BOOT_SIGNATURE_RESET 8'h00
`define EVENT_MASK_RESET 3'h0

`endif

// >>> design/lvd_sysctl_pkg.sv
// Types shared by the system-control bank.
// Assumes nothing of its surroundings.
package lvd_sysctl_pkg;

    // Progress of the two-write unlock sequence
    typedef enum logic [0:0] {
        UNLOCK_IDLE = 1'b0,
        UNLOCK_GOT_FIRST = 1'b1
    } unlock_state_t;

    // Phase of an Avalon-MM access
    typedef enum logic [0:0] {
        BUS_WAIT = 1'b0,
        BUS_ACK = 1'b1
    } bus_phase_t;

endpackage

// >>> design/level_filter_sync.sv
// Three-flop synchroniser with agreement filter for one asynchronous level.
// Assumes the input may change at any time relative to the clock.
`timescale 1ns/100ps

module level_filter_sync (
    input wire logic clk_i,     // Sampling clock
    input wire logic rst_n_i,   // Asynchronous reset, active low
    input wire logic async_i,   // Level from outside the clock domain
    output logic level_o        // Filtered, synchronous level
);

    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic level_reg;
    logic level_next;

    // New level counts once the second and third stages agree
    always_comb begin
        level_next = level_reg;
        if (s2_reg == s3_reg) begin
            level_next = s3_reg;
        end
    end

    // Shift chain and filtered level
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            level_reg <= 1'b0;
        end else begin
            s1_reg <= async_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            level_reg <= level_next;
        end
    end

    assign level_o = level_reg;

endmodule // level_filter_sync

// >>> design/lvd_sysctl_regs.sv
// System-control register bank: flash protection unlock, boot signature,
// low-voltage detect control and status, and an event interrupt pair.
// Assumes an Avalon-MM master on MCLK_I, a separate power-on reset that is
// always accompanied by RESET_N_I, and an asynchronous comparator output.
//
// Design decisions made here: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/100ps
`include "lvd_sysctl_map.svh"

// Notes on behaviour
// - Writes of 0x55 then 0xAA to the unlock register set the unlock flag.
// - Any other unlock write, not completing the pair, clears the unlock flag.
// - Unlock flag gates writes to flash block protection registers.
// - Boot signature survives all resets except power-on reset.
// - Low-voltage flag sets on detection and stays until acknowledged.
// - Writing 1 to ack clears the flag only if no longer detected.
// - Interrupt enable makes the flag request a hardware interrupt.
// - Reset enable with detection enabled forces controller reset on detection.
// - Stop enable selects whether detection runs during stop mode.
// - Detect enable turns detection on and qualifies reset and stop enables.
// - Detect and reset enables take only the first write after reset.
// - Bandgap enable switches the reference buffer on or off.
module lvd_sysctl_regs (
    input wire logic MCLK_I,                 // Bus clock, 100 MHz
    input wire logic RESET_N_I,              // Any reset, asynchronous, active low
    input wire logic POR_N_I,                // Power-on reset, asynchronous, active low
    input wire logic [4:0] ADDRESS_I,        // Avalon byte address
    input wire logic READ_I,                 // Avalon read request
    input wire logic WRITE_I,                // Avalon write request
    input wire logic [3:0] BYTEENABLE_I,     // Avalon byte enables
    input wire logic [31:0] WRITEDATA_I,     // Avalon write data
    output logic [31:0] READDATA_O,          // Avalon read data
    output logic WAITREQUEST_O,              // Avalon wait request
    input wire logic LOW_VOLTAGE_I,          // Comparator output, asynchronous
    input wire logic STOP_MODE_I,            // Device is in stop mode
    input wire logic FLASH_PROT_WR_I,        // Write strobe toward protection regs
    output logic FLASH_PROT_WR_O,            // Gated write strobe
    output logic FLASH_PROT_WR_ALLOW_O,      // Protection registers writable
    output logic LOW_VOLTAGE_IRQ_O,          // Low-voltage interrupt request
    output logic LOW_VOLTAGE_RESET_O,        // Controller reset request
    output logic LOW_VOLTAGE_DETECT_ON_O,    // Detector powered
    output logic BANDGAP_BUFFER_ON_O,        // Bandgap buffer enable
    output logic IRQ_O                       // Combined event interrupt
);

    logic lv_level;
    logic req;
    logic take;
    logic wr_take;
    logic rd_take;
    logic wr_lane0;
    logic [7:0] wr_byte;
    lvd_sysctl_pkg::bus_phase_t phase_reg;
    lvd_sysctl_pkg::bus_phase_t phase_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    lvd_sysctl_pkg::unlock_state_t unlock_state_reg;
    lvd_sysctl_pkg::unlock_state_t unlock_state_next;
    logic unlock_flag_reg;
    logic unlock_flag_next;
    logic [7:0] signature_reg;
    logic [7:0] signature_next;
    logic lv_flag_reg;
    logic lv_flag_next;
    logic irq_en_reg;
    logic irq_en_next;
    logic reset_en_reg;
    logic reset_en_next;
    logic stop_en_reg;
    logic stop_en_next;
    logic detect_en_reg;
    logic detect_en_next;
    logic bandgap_en_reg;
    logic bandgap_en_next;
    logic once_done_reg;
    logic once_done_next;
    logic lv_reset_reg;
    logic lv_reset_next;
    logic [`EV_WIDTH-1:0] ev_status_reg;
    logic [`EV_WIDTH-1:0] ev_status_next;
    logic [`EV_WIDTH-1:0] ev_mask_reg;
    logic [`EV_WIDTH-1:0] ev_mask_next;
    logic detecting;
    logic detected;
    logic [`EV_WIDTH-1:0] events;
    logic [7:0] lv_ctrl_view;
    // Reset image of the low-voltage register, split into its fields on reset
    localparam logic [7:0] lv_ctrl_reset_value = `LV_CTRL_RESET;

    // Comparator output enters the clock domain
    level_filter_sync lv_sync (
        .clk_i(MCLK_I),
        .rst_n_i(RESET_N_I),
        .async_i(LOW_VOLTAGE_I),
        .level_o(lv_level)
    );

    // Bus handshake: one wait cycle, then the access is taken
    assign req = READ_I | WRITE_I;
    assign take = req & (phase_reg == lvd_sysctl_pkg::BUS_ACK);
    assign wr_take = take & WRITE_I;
    assign rd_take = take & READ_I;
    assign wr_lane0 = wr_take & BYTEENABLE_I[0];
    assign wr_byte = WRITEDATA_I[7:0];
    assign WAITREQUEST_O = req & (phase_reg != lvd_sysctl_pkg::BUS_ACK);

    // Detector running: enabled, and either awake or allowed in stop mode
    assign detecting = detect_en_reg & (~STOP_MODE_I | stop_en_reg);
    assign detected = detecting & lv_level;

    // Readable view of the low-voltage register; ack and bit 1 read zero
    always_comb begin
        lv_ctrl_view = 8'h00;
        lv_ctrl_view[`LV_FLAG_BIT] = lv_flag_reg;
        lv_ctrl_view[`LV_IRQ_EN_BIT] = irq_en_reg;
        lv_ctrl_view[`LV_RESET_EN_BIT] = reset_en_reg;
        lv_ctrl_view[`LV_STOP_EN_BIT] = stop_en_reg;
        lv_ctrl_view[`LV_DETECT_EN_BIT] = detect_en_reg;
        lv_ctrl_view[`LV_BANDGAP_EN_BIT] = bandgap_en_reg;
    end

    // Bus phase and read data capture during the wait cycle
    always_comb begin
        phase_next = lvd_sysctl_pkg::BUS_WAIT;
        rdata_next = rdata_reg;
        if (req && phase_reg == lvd_sysctl_pkg::BUS_WAIT) begin
            phase_next = lvd_sysctl_pkg::BUS_ACK;
        end
        if (READ_I && phase_reg == lvd_sysctl_pkg::BUS_WAIT) begin
            rdata_next = 32'h0000_0000;
            unique case (ADDRESS_I & 5'h1C)
                `OFS_FLASH_PROTECT_UNLOCK: begin
                    rdata_next[`UNLOCK_FLAG_BIT] = unlock_flag_reg;
                end
                `OFS_BOOT_SIGNATURE: begin
                    rdata_next[7:0] = signature_reg;
                end
                `OFS_LOW_VOLTAGE_CONTROL_STATUS: begin
                    rdata_next[7:0] = lv_ctrl_view;
                end
                `OFS_EVENT_STATUS: begin
                    rdata_next[`EV_WIDTH-1:0] = ev_status_reg;
                end
                `OFS_EVENT_MASK: begin
                    rdata_next[`EV_WIDTH-1:0] = ev_mask_reg;
                end
                default: begin
                    rdata_next = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            phase_reg <= lvd_sysctl_pkg::BUS_WAIT;
            rdata_reg <= 32'h0000_0000;
        end else begin
            phase_reg <= phase_next;
            rdata_reg <= rdata_next;
        end
    end

    assign READDATA_O = rdata_reg;

    // Unlock sequence: the pair must arrive as two consecutive writes to the unlock register
    always_comb begin
        unlock_state_next = unlock_state_reg;
        unlock_flag_next = unlock_flag_reg;
        if (wr_lane0 && (ADDRESS_I & 5'h1C) == `OFS_FLASH_PROTECT_UNLOCK) begin
            if (unlock_state_reg == lvd_sysctl_pkg::UNLOCK_GOT_FIRST &&
                wr_byte == `UNLOCK_SECOND_CODE) begin
                unlock_flag_next = 1'b1;
            end else begin
                unlock_flag_next = 1'b0;
            end
            if (wr_byte == `UNLOCK_FIRST_CODE) begin
                unlock_state_next = lvd_sysctl_pkg::UNLOCK_GOT_FIRST;
            end else begin
                unlock_state_next = lvd_sysctl_pkg::UNLOCK_IDLE;
            end
        end
    end

    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            unlock_state_reg <= lvd_sysctl_pkg::UNLOCK_IDLE;
            unlock_flag_reg <= 1'b0;
        end else begin
            unlock_state_reg <= unlock_state_next;
            unlock_flag_reg <= unlock_flag_next;
        end
    end

    // Protection register writes pass only while unlocked
    assign FLASH_PROT_WR_ALLOW_O = unlock_flag_reg;
    assign FLASH_PROT_WR_O = FLASH_PROT_WR_I & unlock_flag_reg;

    // Boot signature: plain read/write byte
    always_comb begin
        signature_next = signature_reg;
        if (wr_lane0 && (ADDRESS_I & 5'h1C) == `OFS_BOOT_SIGNATURE) begin
            signature_next = wr_byte;
        end
    end

    // Only power-on reset clears the signature
    always_ff @(posedge MCLK_I or negedge POR_N_I) begin
        if (!POR_N_I) begin
            signature_reg <= `BOOT_SIGNATURE_RESET;
        end else begin
            signature_reg <= signature_next;
        end
    end

    // Low-voltage control fields, flag and reset request
    always_comb begin
        lv_flag_next = lv_flag_reg;
        irq_en_next = irq_en_reg;
        reset_en_next = reset_en_reg;
        stop_en_next = stop_en_reg;
        detect_en_next = detect_en_reg;
        bandgap_en_next = bandgap_en_reg;
        once_done_next = once_done_reg;
        if (wr_lane0 && (ADDRESS_I & 5'h1C) == `OFS_LOW_VOLTAGE_CONTROL_STATUS) begin
            if (wr_byte[`LV_ACK_BIT] && !detected) begin
                lv_flag_next = 1'b0;
            end
            irq_en_next = wr_byte[`LV_IRQ_EN_BIT];
            stop_en_next = wr_byte[`LV_STOP_EN_BIT];
            bandgap_en_next = wr_byte[`LV_BANDGAP_EN_BIT];
            once_done_next = 1'b1;
            if (!once_done_reg) begin
                reset_en_next = wr_byte[`LV_RESET_EN_BIT];
                detect_en_next = wr_byte[`LV_DETECT_EN_BIT];
            end
        end
        if (detected) begin
            lv_flag_next = 1'b1;
        end
        lv_reset_next = detected & detect_en_reg & reset_en_reg;
    end

    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            lv_flag_reg <= lv_ctrl_reset_value[`LV_FLAG_BIT];
            irq_en_reg <= lv_ctrl_reset_value[`LV_IRQ_EN_BIT];
            reset_en_reg <= lv_ctrl_reset_value[`LV_RESET_EN_BIT];
            stop_en_reg <= lv_ctrl_reset_value[`LV_STOP_EN_BIT];
            detect_en_reg <= lv_ctrl_reset_value[`LV_DETECT_EN_BIT];
            bandgap_en_reg <= lv_ctrl_reset_value[`LV_BANDGAP_EN_BIT];
            once_done_reg <= 1'b0;
            lv_reset_reg <= 1'b0;
        end else begin
            lv_flag_reg <= lv_flag_next;
            irq_en_reg <= irq_en_next;
            reset_en_reg <= reset_en_next;
            stop_en_reg <= stop_en_next;
            detect_en_reg <= detect_en_next;
            bandgap_en_reg <= bandgap_en_next;
            once_done_reg <= once_done_next;
            lv_reset_reg <= lv_reset_next;
        end
    end

    // Low-voltage outputs
    assign LOW_VOLTAGE_IRQ_O = lv_flag_reg & irq_en_reg;
    assign LOW_VOLTAGE_RESET_O = lv_reset_reg;
    assign LOW_VOLTAGE_DETECT_ON_O = detecting;
    assign BANDGAP_BUFFER_ON_O = bandgap_en_reg;

    // Events feeding the sticky status register
    always_comb begin
        events = '0;
        events[`EV_LOW_VOLTAGE_BIT] = detected & ~lv_flag_reg;
        events[`EV_UNLOCK_SET_BIT] = unlock_flag_next & ~unlock_flag_reg;
        events[`EV_UNLOCK_CLEAR_BIT] = ~unlock_flag_next & unlock_flag_reg;
    end

    // Read clears the bits it returned; a new event wins over the clear
    always_comb begin
        ev_status_next = ev_status_reg;
        ev_mask_next = ev_mask_reg;
        if (rd_take && (ADDRESS_I & 5'h1C) == `OFS_EVENT_STATUS) begin
            ev_status_next = ev_status_reg & ~rdata_reg[`EV_WIDTH-1:0];
        end
        if (wr_lane0 && (ADDRESS_I & 5'h1C) == `OFS_EVENT_MASK) begin
            ev_mask_next = wr_byte[`EV_WIDTH-1:0];
        end
        ev_status_next = ev_status_next | events;
    end

    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            ev_status_reg <= '0;
            ev_mask_reg <= `EVENT_MASK_RESET;
        end else begin
            ev_status_reg <= ev_status_next;
            ev_mask_reg <= ev_mask_next;
        end
    end

    // Combined interrupt, level while any unmasked event is pending
    assign IRQ_O = |(ev_status_reg & ev_mask_reg);

endmodule // lvd_sysctl_regs

// >>> verification/lvd_sysctl_regs_checker.sv
// Concurrent checks on the ports of the system-control register bank.
// Assumes one clock, MCLK_I, and RESET_N_I as its asynchronous reset.
`timescale 1ns/100ps

module lvd_sysctl_regs_checker (
    input wire logic MCLK_I,                  // Bus clock
    input wire logic RESET_N_I,               // Reset, active low
    input wire logic [4:0] ADDRESS_I,         // Byte address
    input wire logic READ_I,                  // Read request
    input wire logic WRITE_I,                 // Write request
    input wire logic [3:0] BYTEENABLE_I,      // Byte enables
    input wire logic [31:0] WRITEDATA_I,      // Write data
    input wire logic [31:0] READDATA_O,       // Read data
    input wire logic WAITREQUEST_O,           // Wait request
    input wire logic STOP_MODE_I,             // Stop mode
    input wire logic FLASH_PROT_WR_I,         // Raw protection write
    input wire logic FLASH_PROT_WR_O,         // Gated protection write
    input wire logic FLASH_PROT_WR_ALLOW_O,   // Unlock flag
    input wire logic LOW_VOLTAGE_RESET_O,     // Reset request
    input wire logic LOW_VOLTAGE_DETECT_ON_O, // Detector on
    input wire logic BANDGAP_BUFFER_ON_O      // Bandgap buffer on
);
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!RESET_N_I);

    // A write on lane 0 that the bank accepts at this edge
    logic taken_wr;
    assign taken_wr = WRITE_I && !WAITREQUEST_O && BYTEENABLE_I[0];

    a_prot_gate: assert property (FLASH_PROT_WR_O == (FLASH_PROT_WR_I && FLASH_PROT_WR_ALLOW_O))
        else $error("protection write not gated by unlock flag");
    a_unlock_hold: assert property ($changed(FLASH_PROT_WR_ALLOW_O) |->
        $past(taken_wr && ADDRESS_I[4:2] == 3'h0))
        else $error("unlock flag moved without an unlock write");
    a_unlock_clear: assert property (taken_wr && ADDRESS_I[4:2] == 3'h0 &&
        WRITEDATA_I[7:0] != 8'hAA |=> !FLASH_PROT_WR_ALLOW_O)
        else $error("unlock flag survived a non-completing write");
    a_wait_one: assert property ($rose(READ_I || WRITE_I) |-> WAITREQUEST_O ##1 !WAITREQUEST_O)
        else $error("wait request not one cycle");
    a_ack_once: assert property (!WAITREQUEST_O && (READ_I || WRITE_I) |=>
        WAITREQUEST_O || !(READ_I || WRITE_I))
        else $error("answer held longer than one cycle");
    a_reset_qual: assert property (LOW_VOLTAGE_RESET_O |-> $past(LOW_VOLTAGE_DETECT_ON_O))
        else $error("reset request while detection off");
    a_detect_src: assert property ($changed(LOW_VOLTAGE_DETECT_ON_O) |->
        $changed(STOP_MODE_I) || $past(taken_wr && ADDRESS_I[4:2] == 3'h2))
        else $error("detector switched without cause");
    a_bandgap_wr: assert property ($changed(BANDGAP_BUFFER_ON_O) |->
        $past(taken_wr && ADDRESS_I[4:2] == 3'h2) && BANDGAP_BUFFER_ON_O == $past(WRITEDATA_I[0]))
        else $error("bandgap buffer does not follow its write");
    a_ctrl_zero: assert property (READ_I && !WAITREQUEST_O && ADDRESS_I[4:2] == 3'h2 |->
        READDATA_O[6] == 1'b0 && READDATA_O[1] == 1'b0 && READDATA_O[31:8] == 24'h000000)
        else $error("control read shows nonzero constant bits");
endmodule // lvd_sysctl_regs_checker

bind lvd_sysctl_regs lvd_sysctl_regs_checker chk_u (.MCLK_I, .RESET_N_I, .ADDRESS_I, .READ_I,
    .WRITE_I, .BYTEENABLE_I, .WRITEDATA_I, .READDATA_O, .WAITREQUEST_O, .STOP_MODE_I,
    .FLASH_PROT_WR_I, .FLASH_PROT_WR_O, .FLASH_PROT_WR_ALLOW_O, .LOW_VOLTAGE_RESET_O,
    .LOW_VOLTAGE_DETECT_ON_O, .BANDGAP_BUFFER_ON_O);

// >>> verification/lvd_sysctl_regs_bench.sv
// Self-checking bench for the system-control register bank.
// Assumes the design and checker files are compiled first.
`timescale 1ns/100ps

module lvd_sysctl_regs_bench;
    logic MCLK_I = 1'b0;
    logic RESET_N_I = 1'b0;
    logic POR_N_I = 1'b0;
    logic [4:0] ADDRESS_I = 5'h00;
    logic READ_I = 1'b0;
    logic WRITE_I = 1'b0;
    logic [3:0] BYTEENABLE_I = 4'hF;
    logic [31:0] WRITEDATA_I = 32'h00000000;
    logic LOW_VOLTAGE_I = 1'b0;
    logic STOP_MODE_I = 1'b0;
    logic FLASH_PROT_WR_I = 1'b1;
    logic [31:0] READDATA_O;
    logic WAITREQUEST_O, FLASH_PROT_WR_O, FLASH_PROT_WR_ALLOW_O, LOW_VOLTAGE_IRQ_O;
    logic LOW_VOLTAGE_RESET_O, LOW_VOLTAGE_DETECT_ON_O, BANDGAP_BUFFER_ON_O, IRQ_O;
    int mismatches = 0;
    int n_compared = 0;
    typedef struct {logic [4:0] adr; logic [7:0] wd; logic [7:0] rd;} row_t;
    // Write, then read back: address, data written, value expected
    row_t rows [12] = '{'{5'h10, 8'h07, 8'h07}, '{5'h00, 8'h55, 8'h00}, '{5'h00, 8'hAA, 8'h01},
        '{5'h00, 8'h12, 8'h00}, '{5'h00, 8'h55, 8'h00}, '{5'h00, 8'h55, 8'h00},
        '{5'h00, 8'hAA, 8'h01}, '{5'h04, 8'hA5, 8'hA5}, '{5'h08, 8'h2D, 8'h2D},
        '{5'h08, 8'h17, 8'h05}, '{5'h08, 8'h28, 8'h2C}, '{5'h14, 8'hFF, 8'h00}};

    lvd_sysctl_regs dut_u (.MCLK_I, .RESET_N_I, .POR_N_I, .ADDRESS_I, .READ_I, .WRITE_I,
        .BYTEENABLE_I, .WRITEDATA_I, .READDATA_O, .WAITREQUEST_O, .LOW_VOLTAGE_I, .STOP_MODE_I,
        .FLASH_PROT_WR_I, .FLASH_PROT_WR_O, .FLASH_PROT_WR_ALLOW_O, .LOW_VOLTAGE_IRQ_O,
        .LOW_VOLTAGE_RESET_O, .LOW_VOLTAGE_DETECT_ON_O, .BANDGAP_BUFFER_ON_O, .IRQ_O);

    // Clock, 100 MHz
    always #5 MCLK_I = ~MCLK_I;

    task automatic end_sim();
        $display("Compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One Avalon access; holds the request until wait request is seen low
    task automatic bus(input logic wr, input logic [4:0] adr, input logic [7:0] wd,
        output logic [31:0] got);
        int k;
        WRITE_I <= wr;
        READ_I <= !wr;
        ADDRESS_I <= adr;
        WRITEDATA_I <= {24'h000000, wd};
        k = 0;
        // Wait request and read data are taken at the same rising edge
        do begin
            @(posedge MCLK_I);
            k++;
        end while (WAITREQUEST_O !== 1'b0 && k < 50);
        got = READDATA_O;
        if (WAITREQUEST_O !== 1'b0) mismatches++;
        WRITE_I <= 1'b0;
        READ_I <= 1'b0;
        @(posedge MCLK_I);
    endtask

    task automatic wr(input logic [4:0] adr, input logic [7:0] wd);
        logic [31:0] junk;
        bus(1'b1, adr, wd, junk);
    endtask

    task automatic rd(input logic [4:0] adr, input logic [7:0] exp, input string nm);
        logic [31:0] got;
        bus(1'b0, adr, 8'h00, got);
        chk(nm, got, {24'h000000, exp});
    endtask

    // Reset pulse; power-on reset too when por is set
    task automatic rst(input logic por);
        RESET_N_I <= 1'b0;
        POR_N_I <= !por;
        repeat (6) @(posedge MCLK_I);
        RESET_N_I <= 1'b1;
        POR_N_I <= 1'b1;
        @(posedge MCLK_I);
    endtask

    // Watchdog against a hung handshake
    initial begin
        #50000;
        mismatches++;
        end_sim();
    end

    initial begin
        repeat (6) @(posedge MCLK_I);
        RESET_N_I <= 1'b1;
        POR_N_I <= 1'b1;
        @(posedge MCLK_I);
        // Table of ordinary accesses
        foreach (rows[i]) begin
            wr(rows[i].adr, rows[i].wd);
            rd(rows[i].adr, rows[i].rd, "readback");
            @(negedge MCLK_I);
            if (rows[i].adr == 5'h00) chk("prot_wr", FLASH_PROT_WR_O, rows[i].rd[0]);
            if (rows[i].adr == 5'h08) chk("bandgap", BANDGAP_BUFFER_ON_O, rows[i].rd[0]);
            @(posedge MCLK_I);
        end
        $display("Table test done");
        // Event status, mask and combined interrupt
        @(negedge MCLK_I);
        chk("irq", IRQ_O, 1'b1);
        @(posedge MCLK_I);
        rd(5'h0C, 8'h06, "status");
        rd(5'h0C, 8'h00, "status");
        wr(5'h10, 8'h00);
        wr(5'h00, 8'h12);
        @(negedge MCLK_I);
        chk("irq", IRQ_O, 1'b0);
        chk("prot_wr", FLASH_PROT_WR_O, 1'b0);
        @(posedge MCLK_I);
        rd(5'h0C, 8'h04, "status");
        wr(5'h10, 8'h07);
        $display("Event test done");
        // Low-voltage flag, acknowledge and interrupt
        LOW_VOLTAGE_I <= 1'b1;
        repeat (10) @(posedge MCLK_I);
        rd(5'h08, 8'hAC, "ctrl");
        wr(5'h08, 8'h6C);
        rd(5'h08, 8'hAC, "ctrl");
        @(negedge MCLK_I);
        chk("lv_irq", LOW_VOLTAGE_IRQ_O, 1'b1);
        chk("lv_reset", LOW_VOLTAGE_RESET_O, 1'b0);
        @(posedge MCLK_I);
        LOW_VOLTAGE_I <= 1'b0;
        repeat (10) @(posedge MCLK_I);
        rd(5'h08, 8'hAC, "ctrl");
        wr(5'h08, 8'h6C);
        rd(5'h08, 8'h2C, "ctrl");
        @(negedge MCLK_I);
        chk("lv_irq", LOW_VOLTAGE_IRQ_O, 1'b0);
        @(posedge MCLK_I);
        rd(5'h0C, 8'h01, "status");
        wr(5'h08, 8'h0C);
        LOW_VOLTAGE_I <= 1'b1;
        repeat (10) @(posedge MCLK_I);
        rd(5'h08, 8'h8C, "ctrl");
        @(negedge MCLK_I);
        chk("lv_irq", LOW_VOLTAGE_IRQ_O, 1'b0);
        @(posedge MCLK_I);
        $display("Low-voltage test done");
        // Stop mode with and without the stop enable
        wr(5'h08, 8'h04);
        STOP_MODE_I <= 1'b1;
        @(negedge MCLK_I);
        chk("detect_on", LOW_VOLTAGE_DETECT_ON_O, 1'b0);
        @(posedge MCLK_I);
        wr(5'h08, 8'h0C);
        @(negedge MCLK_I);
        chk("detect_on", LOW_VOLTAGE_DETECT_ON_O, 1'b1);
        @(posedge MCLK_I);
        STOP_MODE_I <= 1'b0;
        LOW_VOLTAGE_I <= 1'b0;
        repeat (10) @(posedge MCLK_I);
        $display("Stop test done");
        // Ordinary reset, write-once commit, then power-on reset
        rst(1'b0);
        rd(5'h04, 8'hA5, "signature");
        rd(5'h08, 8'h1C, "ctrl");
        wr(5'h08, 8'h00);
        wr(5'h08, 8'h14);
        rd(5'h08, 8'h00, "ctrl");
        @(negedge MCLK_I);
        chk("detect_on", LOW_VOLTAGE_DETECT_ON_O, 1'b0);
        @(posedge MCLK_I);
        rst(1'b0);
        wr(5'h08, 8'h14);
        LOW_VOLTAGE_I <= 1'b1;
        repeat (10) @(posedge MCLK_I);
        @(negedge MCLK_I);
        chk("lv_reset", LOW_VOLTAGE_RESET_O, 1'b1);
        @(posedge MCLK_I);
        LOW_VOLTAGE_I <= 1'b0;
        rst(1'b1);
        rd(5'h04, 8'h00, "signature");
        $display("Reset test done");
        end_sim();
    end
endmodule // lvd_sysctl_regs_bench
